// ### core/cctpm_pkg.sv
package cctpm_pkg;
  localparam int          CNT_W        = 16;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_OPTION   = 8'h04;
  localparam logic [7:0]  OFS_EDGE_SEL = 8'h08;
  localparam logic [7:0]  OFS_CCR0     = 8'h0c;
  localparam logic [7:0]  OFS_CCR1     = 8'h10;
  localparam logic [7:0]  OFS_COUNT    = 8'h14;
  localparam logic [7:0]  OFS_BIT_CLR  = 8'h18;
  // control_reg_0 fields
  localparam int          CTRL_CE_BIT  = 0;
  localparam int          CTRL_MODE_LO = 1;
  // option_reg_0 fields
  localparam int          OPT_FLAG_BIT = 0;
  localparam int          OPT_CS0_BIT  = 4;
  localparam int          OPT_CS1_BIT  = 5;
  localparam logic [2:0]  MODE_FREE    = 3'h5;
  localparam logic [2:0]  MODE_PULSE   = 3'h6;
  localparam logic [1:0]  EDGE_NONE    = 2'h0;
  localparam logic [1:0]  EDGE_RISE    = 2'h1;
  localparam logic [1:0]  EDGE_FALL    = 2'h2;
  localparam logic [1:0]  EDGE_BOTH    = 2'h3;
  localparam logic [15:0] CNT_MAX      = 16'hffff;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [2:0]  MODE_RESET   = 3'h0;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cctpm_bus_t;

  typedef struct packed {
    logic                  ce;
    logic [2:0]            mode;
    logic [1:0]            cs;
    logic [3:0]            es;
    logic                  flag;
    logic [CNT_W-1:0]      cnt;
    logic [1:0][CNT_W-1:0] ccr;
    logic [1:0]            tout;
    logic [1:0]            cc_irq;
    logic                  ov_irq;
    logic [31:0]           rdata;
  } cctpm_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } cctpm_edge_state_t;
endpackage

// ### core/cctpm_edge.sv
`timescale 1ns/1ps
module cctpm_edge (
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire logic       clk_en_in,
  input  wire logic       pin_in,
  input  wire logic [1:0] edge_sel_in,
  output logic            edge_out
);
  import cctpm_pkg::*;

  cctpm_edge_state_t st_q;
  cctpm_edge_state_t st_d;

  // s1 feeds only s2; detection looks at s2 and prev
  always_comb begin
    st_d      = st_q;
    st_d.s1   = pin_in;
    st_d.s2   = st_q.s1;
    st_d.prev = st_q.s2;
  end

  always_comb begin
    case (edge_sel_in)
      EDGE_RISE: edge_out = st_q.s2 & ~st_q.prev;
      EDGE_FALL: edge_out = ~st_q.s2 & st_q.prev;
      EDGE_BOTH: edge_out = st_q.s2 ^ st_q.prev;
      default:   edge_out = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else if (clk_en_in) begin
      st_q <= st_d;
    end
  end
endmodule

// ### core/cctpm_top.sv
`timescale 1ns/1ps
// Behaviour
// - mode 110 plus count enable starts pulse measure
// - pulse mode edge: capture, clear counter, interrupt
// - captured value stays readable after interrupt
// - pulse mode overflow: interrupt, wrap, flag set
// - free-run: two compare intervals, own interrupts
// - free-run: two independent capture measurements
// - flag cleared by bit clear or option write with flag bit 0
// - overflow set beats simultaneous software clear
// - per-register compare or capture select bits
// - compare match: interrupt and toggle timer output
// - free-run capture: copy counter, interrupt, no clear
// - free-run overflow: interrupt, wrap, flag set
module cctpm_top (
  input  wire logic                 mclk_in,
  input  wire logic                 reset_in,
  input  wire logic                 clk_en_in,
  input  wire cctpm_pkg::cctpm_bus_t bus_in,
  output logic [31:0]               rdata_out,
  input  wire logic [1:0]           capture_input_in,
  output logic [1:0]                match_capture_irq_out,
  output logic                      wrap_irq_out,
  output logic [1:0]                timer_output_out
);
  import cctpm_pkg::*;

  cctpm_state_t st_q;
  cctpm_state_t st_d;
  logic [1:0]   edge_hit;

  for (genvar i = 0; i < 2; i++) begin : g_edge
    cctpm_edge u_edge (
      .mclk_in     (mclk_in),
      .reset_in    (reset_in),
      .clk_en_in   (clk_en_in),
      .pin_in      (capture_input_in[i]),
      .edge_sel_in (st_q.es[2*i +: 2]),
      .edge_out    (edge_hit[i])
    );
  end

  // bus decode
  logic             ctrl_wr;
  logic             opt_wr;
  logic             es_wr;
  logic             bclr_wr;
  logic [1:0]       ccr_wr;
  logic [2:0]       new_mode;

  // mode and event decode
  logic             free_mode;
  logic             pulse_mode;
  logic             tick;
  logic [1:0]       cap_mode;
  logic [1:0]       cap_ev;
  logic [1:0]       cmp_ev;
  logic             any_cap;
  logic             at_top;
  logic             ovf_ev;
  logic             clr_by_bit;
  logic             clr_by_opt;
  logic             flag_clr;
  logic             start_free;
  logic [CNT_W-1:0] cnt_inc;

  // read path
  logic [31:0]      rd_word;

  // writes and reads are one-cycle strobes, never both at once
  always_comb begin
    ctrl_wr   = bus_in.wr & (bus_in.addr == OFS_CTRL);
    opt_wr    = bus_in.wr & (bus_in.addr == OFS_OPTION);
    es_wr     = bus_in.wr & (bus_in.addr == OFS_EDGE_SEL);
    bclr_wr   = bus_in.wr & (bus_in.addr == OFS_BIT_CLR);
    ccr_wr[0] = bus_in.wr & (bus_in.addr == OFS_CCR0);
    ccr_wr[1] = bus_in.wr & (bus_in.addr == OFS_CCR1);
    new_mode  = bus_in.wdata[CTRL_MODE_LO +: 3];
  end

  always_comb begin
    free_mode  = (st_q.mode == MODE_FREE);
    pulse_mode = (st_q.mode == MODE_PULSE);
    tick       = st_q.ce & (free_mode | pulse_mode);
    for (int m = 0; m < 2; m++) begin
      cap_mode[m] = pulse_mode | (free_mode & st_q.cs[m]);
      cap_ev[m]   = tick & cap_mode[m] & edge_hit[m];
      cmp_ev[m]   = tick & free_mode & ~st_q.cs[m] & (st_q.cnt == st_q.ccr[m]);
    end
    any_cap    = |cap_ev;
    at_top     = (st_q.cnt == CNT_MAX);
    // in pulse mode an edge at the top count restarts from zero, no overflow
    ovf_ev     = tick & at_top & ~(pulse_mode & any_cap);
    clr_by_bit = bclr_wr & bus_in.wdata[OPT_FLAG_BIT];
    clr_by_opt = opt_wr & ~bus_in.wdata[OPT_FLAG_BIT];
    flag_clr   = clr_by_bit | clr_by_opt;
    start_free = ctrl_wr & bus_in.wdata[CTRL_CE_BIT] & ~st_q.ce & (new_mode == MODE_FREE);
    cnt_inc    = st_q.cnt + CNT_W'(1);
  end

  // unmapped and write-only offsets read zero
  always_comb begin
    rd_word = '0;
    case (bus_in.addr)
      OFS_CTRL:     rd_word = {28'h0000000, st_q.mode, st_q.ce};
      OFS_OPTION:   rd_word = {26'h0000000, st_q.cs, 3'h0, st_q.flag};
      OFS_EDGE_SEL: rd_word = {28'h0000000, st_q.es};
      OFS_CCR0:     rd_word = {16'h0000, st_q.ccr[0]};
      OFS_CCR1:     rd_word = {16'h0000, st_q.ccr[1]};
      OFS_COUNT:    rd_word = {16'h0000, st_q.cnt};
      default:      rd_word = '0;
    endcase
  end

  always_comb begin
    st_d = st_q;

    // counter: wraps at the top, restarts on a pulse-mode capture
    if (tick) begin
      if (pulse_mode & any_cap) begin
        st_d.cnt = CNT_ZERO;
      end else if (at_top) begin
        st_d.cnt = CNT_ZERO;
      end else begin
        st_d.cnt = cnt_inc;
      end
    end
    // stopping also zeroes the count, so a restart begins from the bottom
    if (ctrl_wr & ~bus_in.wdata[CTRL_CE_BIT]) begin
      st_d.cnt = CNT_ZERO;
    end

    // capture wins over software writes to the same register
    for (int m = 0; m < 2; m++) begin
      if (ccr_wr[m]) begin
        st_d.ccr[m] = bus_in.wdata[CNT_W-1:0];
      end
      if (cap_ev[m]) begin
        st_d.ccr[m] = st_q.cnt;
      end
    end

    // interrupts are single-cycle pulses
    for (int m = 0; m < 2; m++) begin
      st_d.cc_irq[m] = cap_ev[m] | cmp_ev[m];
    end
    st_d.ov_irq = ovf_ev;

    // outputs toggle on match and invert together when free-run starts
    for (int m = 0; m < 2; m++) begin
      if (cmp_ev[m]) begin
        st_d.tout[m] = ~st_q.tout[m];
      end
    end
    if (start_free) begin
      st_d.tout = ~st_q.tout;
    end

    // set wins over a clear in the same cycle
    st_d.flag = ovf_ev | (st_q.flag & ~flag_clr);

    // configuration registers
    if (ctrl_wr) begin
      st_d.ce   = bus_in.wdata[CTRL_CE_BIT];
      st_d.mode = new_mode;
    end
    if (opt_wr) begin
      st_d.cs = {bus_in.wdata[OPT_CS1_BIT], bus_in.wdata[OPT_CS0_BIT]};
    end
    if (es_wr) begin
      st_d.es = bus_in.wdata[3:0];
    end

    // read data stands one cycle only
    st_d.rdata = bus_in.rd ? rd_word : 32'h00000000;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else if (clk_en_in) begin
      st_q <= st_d;
    end
  end

  assign rdata_out             = st_q.rdata;
  assign match_capture_irq_out = st_q.cc_irq;
  assign wrap_irq_out          = st_q.ov_irq;
  assign timer_output_out      = st_q.tout;
endmodule

// ### dv/cctpm_properties.sv
`timescale 1ns/1ps
module cctpm_properties import cctpm_pkg::*; (
  input wire logic                  mclk_in,
  input wire logic                  reset_in,
  input wire logic                  clk_en_in,
  input wire cctpm_pkg::cctpm_bus_t bus_in,
  input wire logic [31:0]           rdata_out,
  input wire logic [1:0]            capture_input_in,
  input wire logic [1:0]            match_capture_irq_out,
  input wire logic                  wrap_irq_out,
  input wire logic [1:0]            timer_output_out
);
  logic [3:0] ctl_q;
  logic [1:0] es1_q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // mirror of the software setup, so mode-gated checks stay honest
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ctl_q <= 4'h0;
      es1_q <= 2'h0;
    end else if (clk_en_in && bus_in.wr && bus_in.addr == OFS_CTRL) begin
      ctl_q <= bus_in.wdata[3:0];
    end else if (clk_en_in && bus_in.wr && bus_in.addr == OFS_EDGE_SEL) begin
      es1_q <= bus_in.wdata[3:2];
    end
  end
  chk_rdata_idle: assert property (clk_en_in && !bus_in.rd |=> rdata_out == 32'h0)
    else $error("read data not idle");
  chk_upper_zero: assert property (rdata_out[31:16] == 16'h0)
    else $error("upper read bits set");
  chk_clr_read: assert property (bus_in.rd && bus_in.addr == OFS_BIT_CLR
    |=> rdata_out == 32'h0) else $error("bit clear reads nonzero");
  chk_cc_pulse: assert property (clk_en_in && match_capture_irq_out[0]
    |=> !match_capture_irq_out[0]) else $error("match pulse too long");
  chk_wrap_gap: assert property (clk_en_in && wrap_irq_out |=> !wrap_irq_out [*8])
    else $error("wrap pulse repeats");
  chk_tout_cause: assert property ($changed(timer_output_out[1]) && !$past(reset_in)
    && !$past(bus_in.wr) && !$past(bus_in.wr, 2) |-> match_capture_irq_out[1])
    else $error("output toggled without match");
  chk_stop_quiet: assert property ((!ctl_q[0]) [*3] |-> !wrap_irq_out)
    else $error("wrap while stopped");
  chk_pulse_capture: assert property (ctl_q == 4'hd && es1_q == EDGE_RISE
    && $rose(capture_input_in[1]) |-> ##[3:5] match_capture_irq_out[1])
    else $error("capture interrupt missing");
  cover property (wrap_irq_out);
  cover property (match_capture_irq_out[1]);
  cover property (timer_output_out[0]);
endmodule

// ### dv/cctpm_pins.sv
`timescale 1ns/1ps
// external trigger source; input 0 stays quiet since only one trigger may be live
module cctpm_pins (
  input  wire logic       mclk_in,
  input  wire logic [1:0] fire_in,
  output logic [1:0]      pin_out
);
  initial pin_out = 2'h0;
  always @(posedge mclk_in) pin_out <= fire_in & 2'h2;
endmodule

// ### dv/cctpm_bench.sv
`timescale 1ns/1ps
module cctpm_bench;
  import cctpm_pkg::*;
  logic        mclk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        clk_en_in = 1'b1;
  cctpm_bus_t  bus_in = '0;
  logic [31:0] rdata_out;
  logic [1:0]  capture_input_in;
  logic [1:0]  match_capture_irq_out;
  logic        wrap_irq_out;
  logic [1:0]  timer_output_out;
  logic [1:0]  fire = 2'h0;
  logic [31:0] q;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  // address, write data, expected read back
  logic [71:0] rows [7] = '{{OFS_CTRL, 32'ha, 32'ha}, {OFS_OPTION, 32'h31, 32'h30},
    {OFS_EDGE_SEL, 32'h4, 32'h4}, {OFS_CCR0, 32'hffff1234, 32'h1234},
    {OFS_COUNT, 32'h55, 32'h0}, {OFS_BIT_CLR, 32'h1, 32'h0}, {8'h20, 32'h7, 32'h0}};
  always #2 mclk_in = ~mclk_in;
  cctpm_top dut (.mclk_in, .reset_in, .clk_en_in, .bus_in, .rdata_out, .capture_input_in,
    .match_capture_irq_out, .wrap_irq_out, .timer_output_out);
  cctpm_pins pins (.mclk_in, .fire_in(fire), .pin_out(capture_input_in));
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // strobe is sampled at the second edge; read data lands right after it
  task acc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    bus_in <= '{a, d, w, r};
    @(posedge mclk_in);
    bus_in <= '0;
    #1 q = rdata_out;
  endtask
  task wait_irq(input int b);
    for (int i = 0; i < 300 && match_capture_irq_out[b] !== 1'b1; i++) begin
      @(posedge mclk_in);
      #1;
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge mclk_in);
    reset_in <= 1'b0;
    foreach (rows[i]) begin
      acc(1'b1, 1'b0, rows[i][71:64], rows[i][63:32]);
      acc(1'b0, 1'b1, rows[i][71:64], 32'h0);
      chk(q, rows[i][31:0]);
    end
    @(posedge mclk_in);
    reset_in <= 1'b1;
    @(posedge mclk_in);
    reset_in <= 1'b0;
    acc(1'b0, 1'b1, OFS_OPTION, 32'h0);
    chk(q, 32'h0);
    $display("register and reset tests done");
    acc(1'b1, 1'b0, OFS_CCR0, 32'h20);
    acc(1'b1, 1'b0, OFS_CCR1, 32'h40);
    acc(1'b1, 1'b0, OFS_CTRL, 32'hb);
    wait_irq(0);
    chk({30'h0, timer_output_out}, 32'h2);
    acc(1'b1, 1'b0, OFS_CCR0, 32'h41);
    wait_irq(1);
    chk({30'h0, timer_output_out}, 32'h0);
    wait_irq(0);
    chk({30'h0, timer_output_out}, 32'h1);
    acc(1'b1, 1'b0, OFS_CTRL, 32'h0);
    $display("compare test done");
    acc(1'b1, 1'b0, OFS_EDGE_SEL, 32'h4);
    acc(1'b1, 1'b0, OFS_CTRL, 32'hd);
    repeat (65000) @(posedge mclk_in);
    acc(1'b0, 1'b1, OFS_COUNT, 32'h0);
    // land the bit clear on the very edge where the counter wraps
    repeat (16'hffff - q[15:0] - 16'h2) @(posedge mclk_in);
    acc(1'b1, 1'b0, OFS_BIT_CLR, 32'h1);
    acc(1'b0, 1'b1, OFS_OPTION, 32'h0);
    chk(q, 32'h1);
    acc(1'b1, 1'b0, OFS_BIT_CLR, 32'h1);
    acc(1'b0, 1'b1, OFS_OPTION, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, 1'b0, OFS_OPTION, 32'h0);
    acc(1'b0, 1'b1, OFS_OPTION, 32'h0);
    chk(q, 32'h0);
    @(posedge mclk_in);
    fire <= 2'h2;
    repeat (50) @(posedge mclk_in);
    fire <= 2'h0;
    repeat (50) @(posedge mclk_in);
    fire <= 2'h2;
    wait_irq(1);
    acc(1'b0, 1'b1, OFS_CCR1, 32'h0);
    chk(q, 32'h63);
    acc(1'b0, 1'b1, OFS_OPTION, 32'h0);
    chk(q, 32'h0);
    $display("pulse tests done");
    print_verdict;
  end
endmodule
bind cctpm_top cctpm_properties chk (.mclk_in, .reset_in, .clk_en_in, .bus_in, .rdata_out,
  .capture_input_in, .match_capture_irq_out, .wrap_irq_out, .timer_output_out);
